// ---- core/bbt_device.sv ----
/*
  device end of the backplane block framer: buffers received characters,
  frames them into 16-byte input-image blocks, sends status blocks when
  idle, and moves output-image data into a fifo toward the serial port.
  assumes characters arrive already deframed on the i_rx_* strobe and the
  serial transmitter drains o_tx_* with i_tx_ready.
*/
`timescale 1ns/1ns
module bbt_device
  import bbt_pkg::*;
#(
  parameter int BUF_BYTES = RX_BUF_BYTES
)(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  bbt_if.device           bus,
  input  wire logic [7:0] i_rx_data,      // received character
  input  wire logic       i_rx_valid,     // one-cycle character strobe
  input  wire logic       i_rx_term,      // termination condition pulse
  input  wire logic       i_cfg_error,    // port configuration error level
  input  wire logic       i_swap_en,      // receive byte swap option
  input  wire logic       i_stop_on_idle, // shut port when processor stops
  output      logic [7:0] o_tx_data,      // byte to the transmitter
  output      logic       o_tx_valid,     // byte available
  input  wire logic       i_tx_ready,     // transmitter takes byte
  output      logic       o_warm_req,     // warm restart request pulse
  output      logic       o_cold_req,     // cold restart request pulse
  output      logic       o_port_on       // serial port enabled
);
  localparam int AW = $clog2(BUF_BYTES);

  logic [7:0]    ram [BUF_BYTES];  // receive buffer
  bbt_state_type state, next_state;
  logic [AW:0]   fill, next_fill;  // bytes held in current message
  logic [AW:0]   rd, next_rd;      // next byte to frame
  logic [7:0]    seq, next_seq;
  logic          loss, next_loss;
  logic          stat_sel, next_stat_sel;
  logic [15:0]   tx_cnt, next_tx_cnt;   // scans since reset, ram clear cycles included
  logic [15:0]   rx_cnt, next_rx_cnt;   // blocks taken from processor
  logic [127:0]  img, next_img;
  logic          port_on, next_port_on;
  logic          warm, next_warm, cold, next_cold;
  logic          pend, next_pend;       // termination seen, message whole
  logic [AW:0]   left;
  logic [7:0]    cnt8;
  logic [15:0]   err_word;
  logic          wr_img;                // output image taken this cycle
  logic [3:0]    pos;                   // swap-adjusted byte index

  // sequencing, framing and status; one block per scan (one clock)
  always_comb
  begin
    next_state = state;
    next_fill = fill;
    next_rd = rd;
    next_seq = seq + 8'h01;
    next_loss = loss || (i_rx_valid && port_on && state == BBT_SEND); // lost while sending
    next_stat_sel = stat_sel;
    next_tx_cnt = tx_cnt + 16'h0001;
    next_rx_cnt = rx_cnt;
    next_img = img;
    next_pend = pend;
    next_warm = 1'b0;
    next_cold = 1'b0;
    next_port_on = bus.proc_run || !i_stop_on_idle;
    left = fill - rd;
    cnt8 = 8'h00;
    pos = 4'h0;
    err_word = WORD_RST;
    err_word[ERR_CFG_BIT] = i_cfg_error;
    err_word[ERR_LOSS_BIT] = loss;
    wr_img = bus.out_valid && bus.out_ready;
    if (wr_img)
    begin
      next_rx_cnt = rx_cnt + 16'h0001;
      if (bus.out_image[7:0] == ID_WARM)
        next_warm = 1'b1;
      else if (bus.out_image[7:0] == ID_COLD)
        next_cold = 1'b1;
    end
    next_img[SEQ_OFS*8 +: 8] = next_seq;
    case (state)
      BBT_CLEAR:                         // wait for ram clear
      begin
        next_port_on = 1'b0;
        next_rd = rd + 1'b1;
        if (rd == (AW+1)'(BUF_BYTES - 1))
        begin
          next_rd = '0;
          next_state = BBT_IDLE;
        end
      end
      BBT_IDLE:
      begin
        // collecting; overflow beyond buffer drops data and flags loss
        if (i_rx_valid && port_on && !pend)
        begin
          if (fill == (AW+1)'(BUF_BYTES))
            next_loss = 1'b1;
          else
            next_fill = fill + 1'b1;
        end
        else if (i_rx_valid && port_on)
          next_loss = 1'b1;              // previous message still busy
        if (i_rx_term && fill != '0)
          next_pend = 1'b1;
        if (pend)
          next_state = BBT_SEND;
        // status block on every idle scan, including the scan in which pend moves the state to BBT_SEND
        next_stat_sel = !stat_sel;
        next_img[LEN_OFS*8 +: 8] = stat_sel ? LEN_STAT_B : LEN_STAT_A;
        next_img[2*8 +: 16] = {8'h00, seq};
        next_img[4*8 +: 16] = tx_cnt;
        next_img[6*8 +: 16] = rx_cnt;
        next_img[8*8 +: 16] = rx_cnt;
        next_img[10*8 +: 16] = WORD_RST;
        next_img[12*8 +: 16] = err_word;
        next_img[14*8 +: 16] = {15'h0000, port_on};
      end
      default:                           // BBT_SEND
      begin
        if (left > (AW+1)'(DATA_PER_BLK))
        begin
          next_img[LEN_OFS*8 +: 8] = LEN_CONT;
          next_rd = rd + (AW+1)'(DATA_PER_BLK);
        end
        else
        begin
          cnt8 = 8'(left);
          next_img[LEN_OFS*8 +: 8] = cnt8;
          next_rd = '0;
          next_state = BBT_IDLE;
          next_fill = '0;
          next_pend = 1'b0;
        end
        for (int i = 0; i < DATA_PER_BLK; i++)
        begin
          pos = i_swap_en ? 4'(i ^ 1) : 4'(i);
          next_img[(DATA_OFS+i)*8 +: 8] = (AW+1)'(pos) < left ?
            ram[AW'(rd + (AW+1)'(pos))] : 8'h00;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= BBT_CLEAR;
      fill <= '0;
      rd <= '0;
      seq <= SEQ_RST;
      loss <= 1'b0;
      stat_sel <= 1'b0;
      tx_cnt <= WORD_RST;
      rx_cnt <= WORD_RST;
      img <= '0;
      port_on <= 1'b0;
      warm <= 1'b0;
      cold <= 1'b0;
      pend <= 1'b0;
    end
    else
    begin
      state <= next_state;
      fill <= next_fill;
      rd <= next_rd;
      seq <= next_seq;
      loss <= next_loss;
      stat_sel <= next_stat_sel;
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      img <= next_img;
      port_on <= next_port_on;
      warm <= next_warm;
      cold <= next_cold;
      pend <= next_pend;
    end
  end

  // buffer ram: cleared after reset, then written with characters
  always_ff @(posedge i_clk)
  begin
    if (state == BBT_CLEAR)
      ram[rd[AW-1:0]] <= 8'h00;
    else if (state == BBT_IDLE && i_rx_valid && port_on && !pend
             && fill != (AW+1)'(BUF_BYTES))
      ram[fill[AW-1:0]] <= i_rx_data;
  end

  // output image data bytes go through a fifo; data ids only
  logic [7:0]  q_data;
  logic        q_valid;
  logic        q_ready;
  logic [3:0]  widx;                  // byte index while unloading
  logic [3:0]  next_widx;
  logic [111:0] hold, next_hold;
  logic        busy, next_busy;

  always_comb
  begin
    next_widx = widx;
    next_hold = hold;
    next_busy = busy;
    q_valid = busy && port_on;
    q_data = hold[widx*8 +: 8];
    if (wr_img && bus.out_image[7:0] <= ID_DATA_MAX)
    begin
      next_hold = bus.out_image;
      next_widx = 4'h1;
      next_busy = 1'b1;
    end
    else if (q_valid && q_ready)
    begin
      next_widx = widx + 4'h1;
      if (widx == 4'(OUT_IMG_BYTES - 1))
        next_busy = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      widx <= 4'h0;
      hold <= '0;
      busy <= 1'b0;
    end
    else
    begin
      widx <= next_widx;
      hold <= next_hold;
      busy <= next_busy;
    end
  end

  bbt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_data  (q_data),
    .i_valid (q_valid),
    .o_ready (q_ready),
    .o_data  (o_tx_data),
    .o_valid (o_tx_valid),
    .i_ready (i_tx_ready && port_on)
  );

  assign bus.in_image  = img;
  assign bus.in_valid  = (state != BBT_CLEAR);
  assign bus.out_ready = !busy;
  assign o_warm_req    = warm;
  assign o_cold_req    = cold;
  assign o_port_on     = port_on;
endmodule : bbt_device

// ---- shared/bbt_pkg.sv ----
/*
  package for the backplane block transfer framer: image sizes, block codes,
  status layout positions and state encodings shared by both ends.
  assumes a single 50 MHz clock and an active-low asynchronous reset.
*/
package bbt_pkg;
  localparam int IN_IMG_BYTES   = 16;            // input image size
  localparam int OUT_IMG_BYTES  = 14;            // output image size
  localparam int DATA_PER_BLK   = 14;            // data bytes per read block
  localparam int RX_BUF_BYTES   = 4096;          // receive buffer depth
  localparam int FIFO_DEPTH     = 16;            // transmit path fifo depth
  localparam int SEQ_OFS        = 0;             // sequence byte offset
  localparam int LEN_OFS        = 1;             // length byte offset
  localparam int DATA_OFS       = 2;             // first data byte offset
  localparam logic [7:0] ID_DATA_MAX = 8'h7F;    // last normal data id
  localparam logic [7:0] ID_WARM     = 8'hFE;    // warm restart request
  localparam logic [7:0] ID_COLD     = 8'hFF;    // cold restart request
  localparam logic [7:0] LEN_CONT    = 8'hFF;    // continuation marker
  localparam logic [7:0] LEN_STAT_A  = 8'hFC;    // first status layout
  localparam logic [7:0] LEN_STAT_B  = 8'hFD;    // second status layout
  localparam int ERR_CFG_BIT    = 0;             // configuration error bit
  localparam int ERR_LOSS_BIT   = 15;            // receive loss bit
  localparam logic [7:0] SEQ_RST    = 8'h00;     // sequence reset value
  localparam logic [15:0] WORD_RST  = 16'h0000;  // counter reset value

  typedef enum logic [1:0] {
    BBT_CLEAR = 2'b00,  // clearing buffer ram
    BBT_IDLE  = 2'b01,  // collecting characters
    BBT_SEND  = 2'b11   // sending a message in blocks
  } bbt_state_type;
endpackage : bbt_pkg

// ---- shared/bbt_if.sv ----
/*
  interface joining the framer device and the processor end.
  assumes both ends share i_clk; images are handed over whole each scan.
*/
`timescale 1ns/1ns
interface bbt_if;
  logic [127:0] in_image;    // 16-byte input image, byte 0 in bits 7:0
  logic         in_valid;    // device has a fresh image this scan
  logic [111:0] out_image;   // 14-byte output image
  logic         out_valid;   // processor wrote the output image
  logic         out_ready;   // device can take the output image
  logic         proc_run;    // processor is in run state

  modport device (output in_image, output in_valid, input out_image,
                  input out_valid, output out_ready, input proc_run);
  modport host   (input in_image, input in_valid, output out_image,
                  output out_valid, input out_ready, output proc_run);
endinterface : bbt_if

// ---- core/bbt_fifo.sv ----
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock; full and empty are exact.
*/
`timescale 1ns/1ns
module bbt_fifo
  import bbt_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output      logic             o_ready,
  output      logic [WIDTH-1:0] o_data,
  output      logic             o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW:0]      wptr;          // write pointer with wrap bit
  logic [AW:0]      rptr;          // read pointer with wrap bit
  logic [AW:0]      next_wptr;
  logic [AW:0]      next_rptr;
  logic             full;
  logic             empty;

  // full and empty from the wrap bits
  always_comb
  begin
    empty = (wptr == rptr);
    full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
    next_wptr = wptr + ((i_valid && !full) ? 1'b1 : 1'b0);
    next_rptr = rptr + ((!empty && i_ready) ? 1'b1 : 1'b0);
  end

  // pointer registers and storage
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_valid && !full)
      mem[wptr[AW-1:0]] <= i_data;
  end

  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem[rptr[AW-1:0]];
endmodule : bbt_fifo

// ---- core/bbt_host.sv ----
/*
  processor end: watches the input image sequence byte, reassembles
  packets and writes output image blocks supplied by its user side.
  assumes the device end on the same clock through bbt_if.
*/
`timescale 1ns/1ns
module bbt_host
  import bbt_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  bbt_if.host               bus,
  input  wire logic         i_run,        // processor run state
  input  wire logic [111:0] i_wr_image,   // block to send
  input  wire logic         i_wr_valid,   // request to send block
  output      logic         o_wr_ready,   // block accepted this cycle
  output      logic [111:0] o_rd_data,    // 14 data bytes of latest block
  output      logic [7:0]   o_rd_count,   // length byte of latest block
  output      logic         o_rd_valid,   // one-cycle pulse per data block
  output      logic         o_rd_last     // block ends a packet
);
  logic [7:0]   last_seq, next_last_seq;
  logic [111:0] rdd, next_rdd;
  logic [7:0]   rdc, next_rdc;
  logic         rdv, next_rdv, rdl, next_rdl;
  logic         wrr, next_wrr;
  logic [7:0]   len;

  // new block on sequence change; status codes are skipped
  always_comb
  begin
    len = bus.in_image[LEN_OFS*8 +: 8];
    next_last_seq = last_seq;
    next_rdd = rdd;
    next_rdc = rdc;
    next_rdv = 1'b0;
    next_rdl = rdl;
    next_wrr = 1'b0;
    if (bus.in_valid && bus.in_image[7:0] != last_seq)
    begin
      next_last_seq = bus.in_image[7:0];
      if (len != LEN_STAT_A && len != LEN_STAT_B)
      begin
        next_rdd = bus.in_image[127:16];
        next_rdc = len;
        next_rdv = 1'b1;
        next_rdl = (len != LEN_CONT);
      end
    end
    if (i_wr_valid && bus.out_ready && !wrr)
      next_wrr = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      last_seq <= SEQ_RST;
      rdd <= '0;
      rdc <= 8'h00;
      rdv <= 1'b0;
      rdl <= 1'b0;
      wrr <= 1'b0;
    end
    else
    begin
      last_seq <= next_last_seq;
      rdd <= next_rdd;
      rdc <= next_rdc;
      rdv <= next_rdv;
      rdl <= next_rdl;
      wrr <= next_wrr;
    end
  end

  assign bus.out_image = i_wr_image;
  assign bus.out_valid = wrr;
  assign bus.proc_run  = i_run;
  assign o_wr_ready = wrr;
  assign o_rd_data  = rdd;
  assign o_rd_count = rdc;
  assign o_rd_valid = rdv;
  assign o_rd_last  = rdl;
endmodule : bbt_host

// ---- testbench/bbt_checker.sv ----
/*
  interface checker for the block framer: watches the images on bbt_if.
  assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ns
module bbt_checker
  import bbt_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_rst_n,
  input wire logic [127:0] in_image,
  input wire logic         in_valid,
  input wire logic [111:0] out_image,
  input wire logic         out_valid,
  input wire logic         out_ready,
  input wire logic         proc_run
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [7:0] len;         // length byte of the standing image
  logic       stat;        // image holds a status block
  logic       loss_seen;   // receive loss already reported
  logic       next_loss_seen;
  assign len  = in_image[15:8];
  assign stat = in_valid && (len == LEN_STAT_A || len == LEN_STAT_B);

  // loss flag is sticky, so remember the first report
  always_comb
  begin
    next_loss_seen = loss_seen || (stat && in_image[111]);
  end

  // register only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      loss_seen <= 1'b0;
    else
      loss_seen <= next_loss_seen;
  end

  sequence s_cont;
    in_valid && len == LEN_CONT;
  endsequence
  sequence s_last;
    in_valid && len inside {[8'h01:8'h0E]};
  endsequence

  seq_bump_a: assert property (
    in_valid && $past(in_valid) |-> in_image[7:0] == $past(in_image[7:0]) + 8'h01)
    else $error("sequence byte did not advance by one");
  len_legal_a: assert property (
    in_valid |-> len <= 8'h0E || len == LEN_CONT || stat)
    else $error("length byte outside its codes");
  cont_next_a: assert property (
    s_cont |=> s_cont or s_last)
    else $error("continuation block not followed by data");
  last_stat_a: assert property (
    s_last |=> stat)
    else $error("no status block after final block");
  stat_alt_a: assert property (
    in_valid && len == LEN_STAT_A |=> len != LEN_STAT_A)
    else $error("status layout did not alternate");
  valid_stay_a: assert property (
    in_valid |=> in_valid)
    else $error("input image dropped after start");
  out_busy_a: assert property (
    out_valid && out_ready && out_image[7:0] <= ID_DATA_MAX |=> !out_ready)
    else $error("output image taken while bytes queue");
  loss_sticky_a: assert property (
    stat && loss_seen |-> in_image[111])
    else $error("receive loss flag cleared");
  port_run_a: assert property (
    stat && $past(in_valid, 2) && $past(proc_run, 2) |-> in_image[112])
    else $error("port reported off while processor runs");
endmodule : bbt_checker

// ---- testbench/backplane_block_transfer_test.sv ----
/*
  testbench joining device and processor ends through bbt_if.
  assumes 50 MHz clock; ram clear shortened to 64 cycles.
*/
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module backplane_block_transfer_test;
  import bbt_pkg::*;
  typedef struct {int n; logic swap; int blocks;} bbt_row_type;
  logic i_clk = 0, i_rst_n = 0, i_rx_valid = 0, i_rx_term = 0, i_cfg_error = 0;
  logic i_swap_en = 0, i_stop_on_idle = 1, i_tx_ready = 1, i_run = 1, i_wr_valid = 0;
  logic [7:0]   i_rx_data = 8'h00;
  logic [111:0] i_wr_image = '0;
  logic [7:0]   o_tx_data, o_rd_count;
  logic         o_tx_valid, o_warm_req, o_cold_req, o_port_on, o_wr_ready, o_rd_valid, o_rd_last;
  logic [111:0] o_rd_data;
  int           checks = 0, mismatches = 0, cycles = 0, warm_n = 0, cold_n = 0;
  logic [7:0]   tx_q[$];  // bytes handed to the transmitter
  bbt_row_type  rows[6] = '{'{1, 0, 1}, '{2, 1, 1}, '{14, 0, 1}, '{15, 0, 2}, '{28, 1, 2}, '{30, 0, 3}};

  bbt_if bus_if();
  bbt_device #(.BUF_BYTES(64)) bbt_device_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus_if),
    .i_rx_data(i_rx_data), .i_rx_valid(i_rx_valid), .i_rx_term(i_rx_term), .i_cfg_error(i_cfg_error),
    .i_swap_en(i_swap_en), .i_stop_on_idle(i_stop_on_idle), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready), .o_warm_req(o_warm_req), .o_cold_req(o_cold_req), .o_port_on(o_port_on));
  bbt_host bbt_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus_if), .i_run(i_run),
    .i_wr_image(i_wr_image), .i_wr_valid(i_wr_valid), .o_wr_ready(o_wr_ready), .o_rd_data(o_rd_data),
    .o_rd_count(o_rd_count), .o_rd_valid(o_rd_valid), .o_rd_last(o_rd_last));
  bbt_checker bbt_checker_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .in_image(bus_if.in_image),
    .in_valid(bus_if.in_valid), .out_image(bus_if.out_image), .out_valid(bus_if.out_valid),
    .out_ready(bus_if.out_ready), .proc_run(bus_if.proc_run));

  always #10 i_clk = ~i_clk;

  // sample on the falling edge, where registered outputs have settled
  always @(negedge i_clk)
  begin
    warm_n += int'(o_warm_req === 1'b1);
    cold_n += int'(o_cold_req === 1'b1);
    if (o_tx_valid === 1'b1 && i_tx_ready)
      tx_q.push_back(o_tx_data);
  end

  // hang guard: whole run is a few hundred cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // characters back to back, then the termination pulse
  task automatic send_msg(input int n, input int base);
    for (int k = 0; k < n; k++)
    begin
      @(posedge i_clk);
      i_rx_valid <= 1'b1;
      i_rx_data  <= 8'(base + k);
    end
    @(posedge i_clk);
    i_rx_valid <= 1'b0;
    i_rx_term  <= 1'b1;
    @(posedge i_clk);
    i_rx_term  <= 1'b0;
  endtask : send_msg

  // collect read blocks until the whole message is seen
  task automatic get_msg(input int n, input int base, input logic swap, output int blk);
    int rem;
    int t;
    int cnt;
    rem = n;
    t = 0;
    blk = 0;
    while (rem > 0 && t < 400)
    begin
      @(negedge i_clk);
      t++;
      if (o_rd_valid === 1'b1)
      begin
        blk++;
        cnt = (rem > DATA_PER_BLK) ? DATA_PER_BLK : rem;
        `CHK("length byte", (rem > DATA_PER_BLK) ? LEN_CONT : 8'(cnt), o_rd_count)
        `CHK("packet end", logic'(rem <= DATA_PER_BLK), o_rd_last)
        for (int k = 0; k < cnt; k++)
          `CHK("data byte", 8'(base + n - rem + k), o_rd_data[8*(swap ? k ^ 1 : k) +: 8])
        rem -= cnt;
      end
    end
    `CHK("message complete", 0, rem)
  endtask : get_msg

  // wait for a status block in the input image
  task automatic wait_stat;
    int t;
    t = 0;
    do
    begin
      @(negedge i_clk);
      t++;
    end
    while (!(bus_if.in_valid === 1'b1 && bus_if.in_image[15:8] inside {LEN_STAT_A, LEN_STAT_B}) && t < 100);
    `CHK("status block seen", 1, int'(t < 100))
  endtask : wait_stat

  // one output image; a refused image simply waits for space
  task automatic write_img(input logic [111:0] img);
    int t;
    t = 0;
    @(posedge i_clk);
    i_wr_image <= img;
    i_wr_valid <= 1'b1;
    do
    begin
      @(negedge i_clk);
      t++;
    end
    while (o_wr_ready !== 1'b1 && t < 100);
    @(posedge i_clk);
    i_wr_valid <= 1'b0;
  endtask : write_img

  initial
  begin
    int nblk;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (10) @(negedge i_clk);
    `CHK("image during clear", 1'b0, bus_if.in_valid)
    `CHK("port during clear", 1'b0, o_port_on)
    wait_stat();
    `CHK("port after clear", 1'b1, o_port_on)
    foreach (rows[r])
    begin
      @(posedge i_clk);
      i_swap_en <= rows[r].swap;
      fork
        send_msg(rows[r].n, 16 * r);
        get_msg(rows[r].n, 16 * r, rows[r].swap, nblk);
      join
      `CHK("blocks per message", rows[r].blocks, nblk)
    end
    @(posedge i_clk);
    i_swap_en <= 1'b0;
    // characters arriving while a message is pending are lost
    send_msg(3, 8'h50);
    fork
      get_msg(3, 8'h50, 1'b0, nblk);
      begin
        @(posedge i_clk);
        i_rx_valid <= 1'b1;
        @(posedge i_clk);
        i_rx_valid <= 1'b0;
      end
    join
    wait_stat();
    `CHK("loss flag", 1'b1, bus_if.in_image[111])
    `CHK("config flag clear", 1'b0, bus_if.in_image[96])
    @(posedge i_clk);
    i_cfg_error <= 1'b1;
    repeat (4) @(negedge i_clk);
    wait_stat();
    `CHK("config flag", 1'b1, bus_if.in_image[96])
    // stall the transmitter so the second image's bytes fill the fifo and out_ready stays low
    @(posedge i_clk);
    i_tx_ready <= 1'b0;
    write_img({8'h4D, 8'h4C, 8'h4B, 8'h4A, 8'h49, 8'h48, 8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h01});
    fork
      write_img({8'h6D, 8'h6C, 8'h6B, 8'h6A, 8'h69, 8'h68, 8'h67, 8'h66, 8'h65, 8'h64, 8'h63, 8'h62, 8'h61, 8'h02});
      begin
        repeat (30) @(negedge i_clk);
        `CHK("image refused while full", 1'b0, bus_if.out_ready)
        @(posedge i_clk);
        i_tx_ready <= 1'b1;
      end
    join
    repeat (40) @(negedge i_clk);
    `CHK("bytes transmitted", 26, tx_q.size())
    foreach (tx_q[k])
      `CHK("tx byte", 8'(((k < 13) ? 8'h41 : 8'h54) + k), tx_q[k])
    // control ids restart, reserved ids do nothing
    write_img({104'h0, ID_WARM});
    write_img({104'h0, ID_COLD});
    write_img({104'h0, 8'h80});
    repeat (5) @(negedge i_clk);
    `CHK("warm requests", 1, warm_n)
    `CHK("cold requests", 1, cold_n)
    // processor leaves run: port shut only when so configured
    for (int s = 0; s < 2; s++)
    begin
      @(posedge i_clk);
      i_stop_on_idle <= logic'(s);
      i_run <= 1'b0;
      repeat (5) @(negedge i_clk);
      `CHK("port while stopped", logic'(s == 0), o_port_on)
      @(posedge i_clk);
      i_run <= 1'b1;
      repeat (5) @(negedge i_clk);
      `CHK("port after run", 1'b1, o_port_on)
    end
    // reset in mid-run drops the image at once, then the ram clear runs again
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(negedge i_clk);
    `CHK("image in reset", 1'b0, bus_if.in_valid)
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK("image after reset", 1'b0, bus_if.in_valid)
    `CHK("port after reset", 1'b0, o_port_on)
    wait_stat();
    `CHK("loss cleared by reset", 1'b0, bus_if.in_image[111])
    test_done();
  end
endmodule : backplane_block_transfer_test
